// ===== shared/iocfg_pkg.sv
// Operation
// RL1: Three-bit oscillator gain trim at bits 4:2, 000 highest gain, resets 101.
// RL2: Two-bit oscillator low-power trim at bits 1:0, 00 highest power, resets 00.
// RL3: Software should leave both oscillator trim fields at their reset values.
// RL4: Software writes zero to reserved bits of trim and Port 1 config.
// RL5: Each analog bus connect bit closes one pin switch; one connects, reset zero.
// RL6: Connect register index is the port number, bit index is the pin number.
// RL7: Port 4 connect register upper four bits are reserved and read zero.
// RL8: Port 1 config bit 7 raises high-side drive strength and edge ratio.
// RL9: Bits 5:4 pick Port 1 high level: 00/01 3.0V, 10 1.8V, 11 2.5V.
// RL10: Bit 3 lowers Port 1 input thresholds when one, standard when zero.
// RL11: Bit 2 one routes serial clock to P1 pin 0, zero to pin 3.
// RL12: Bit 1 enables Port 1 output regulator; zero drives strong outputs to supply.
// RL13: Bit 0 picks GPIO interrupt style: zero low level, one change since read.
// RL14: GPIO interrupt needs per-pin enable and global GPIO mask bit set too.
// RL15: Port read captures pin values; live pins compared with capture for change.
package iocfg_pkg;

  // ****************************************
  // Geometry
  // ****************************************
  localparam int IOCFG_NPORTS = 5;
  localparam int IOCFG_PINS = 8;

  // ****************************************
  // Register indices (byte address is four times the index)
  // ****************************************
  localparam logic [7:0] IDX_TRIM = 8'hd3;
  localparam logic [7:0] IDX_MUX0 = 8'hd8;
  localparam logic [7:0] IDX_MUX1 = 8'hd9;
  localparam logic [7:0] IDX_MUX2 = 8'hda;
  localparam logic [7:0] IDX_MUX3 = 8'hdb;
  localparam logic [7:0] IDX_P1CFG = 8'hdc;
  localparam logic [7:0] IDX_MUX4 = 8'hdf;
  localparam logic [7:0] IDX_PIE0 = 8'he0;
  localparam logic [7:0] IDX_GMASK = 8'he5;
  localparam logic [7:0] IDX_STAT = 8'he6;
  localparam logic [7:0] IDX_IMASK = 8'he7;
  localparam logic [7:0] IDX_PDATA0 = 8'he8;

  // ****************************************
  // Fields and reset values
  // ****************************************
  localparam int TRIM_GAIN_LSB = 2;
  localparam int TRIM_LP_LSB = 0;
  localparam logic [2:0] RST_GAIN = 3'h5;
  localparam logic [1:0] RST_LP = 2'h0;
  localparam logic [7:0] RST_CONN = 8'h00;
  localparam logic [7:0] PORT4_PIN_MASK = 8'h0f;
  localparam int P1_STRONG = 7;
  localparam int P1_RANGE_LSB = 4;
  localparam int P1_THR = 3;
  localparam int P1_SPI = 2;
  localparam int P1_REG = 1;
  localparam int P1_INT = 0;
  localparam int EV_GPIO = 0;
  localparam int EV_TRIM = 1;
  localparam int EV_NUM = 2;

  // High output level codes of Port 1
  typedef enum logic [1:0] {
    RANGE_3V0 = 2'h0,
    RANGE_3V0_ALT = 2'h1,
    RANGE_1V8 = 2'h2,
    RANGE_2V5 = 2'h3
  } iocfg_range_e;

  // Port 1 output configuration as seen by the pad ring
  typedef struct packed {
    logic strongHighDrive;
    iocfg_range_e highLevel;
    logic inputThresholdReduce;
    logic serialClockPinSelect;
    logic regulatorEnable;
    logic irqOnChange;
  } iocfg_p1cfg_s;

  // One decoded register access from the bus slave
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] idx;
    logic [7:0] data;
  } iocfg_req_s;

endpackage

// ===== verif/iocfg_bank_assertions.sv
`timescale 1ns/100ps
// ******
// Port checker for the register bank
// ******
module iocfg_bank_assertions import iocfg_pkg::*; #(
  parameter int ADDR_W = 10,
  parameter int NPORTS = IOCFG_NPORTS,
  parameter int PINS = IOCFG_PINS
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Register bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // Outputs under watch
  input wire logic serialClock,
  input wire logic [2:0] ampGainTrim,
  input wire logic [1:0] lowPowerTrim,
  input wire logic [NPORTS-1:0][PINS-1:0] analogBusPinConnect,
  input iocfg_p1cfg_s p1Cfg,
  input wire logic serialClockP10,
  input wire logic serialClockP13,
  input wire logic gpioReq
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  // Take and write qualifiers, as the slave sees them
  logic take;
  logic wrTake;
  assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wrTake = take && wb_we_i && wb_sel_i[0];

  // Bus answers one cycle after the take, as a single pulse
  a_ack_next: assert property (take |=> wb_ack_o) else $error("ack late");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  a_rdata_upper: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0) else $error("upper data");
  a_trim_write: assert property (wrTake && wb_adr_i[9:2] == IDX_TRIM |=>
    {ampGainTrim, lowPowerTrim} == $past(wb_dat_i[4:0])) else $error("trim not written");
  // Trim only moves on a trim write, so a stray decode shows here
  a_trim_hold: assert property (!(wrTake && wb_adr_i[9:2] == IDX_TRIM) |=>
    $stable({ampGainTrim, lowPowerTrim})) else $error("trim moved");
  a_mux_write: assert property (wrTake && wb_adr_i[9:4] == 6'h36 |=>
    analogBusPinConnect[$past(wb_adr_i[3:2])] == $past(wb_dat_i[7:0])) else $error("mux write");
  a_port4_upper: assert property (analogBusPinConnect[NPORTS-1][PINS-1:4] == 4'h0)
    else $error("port 4 upper bits set");
  a_p1cfg_write: assert property (wrTake && wb_adr_i[9:2] == IDX_P1CFG
    |=> p1Cfg == {$past(wb_dat_i[7]), $past(wb_dat_i[5:0])}) else $error("port 1 config write");
  a_clk_route: assert property (
    serialClockP10 == (serialClock && p1Cfg.serialClockPinSelect) &&
    serialClockP13 == (serialClock && !p1Cfg.serialClockPinSelect)) else $error("clock route");

  // Main scenarios reached
  c_p1_write: cover property (wrTake && wb_adr_i[9:2] == IDX_P1CFG);
  c_read: cover property (take && !wb_we_i ##1 wb_ack_o);
  c_gpio: cover property ($rose(gpioReq));
endmodule

bind iocfg_bank iocfg_bank_assertions #(.ADDR_W(ADDR_W), .NPORTS(NPORTS), .PINS(PINS)) chk (
  .sys_clk(sys_clk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .serialClock(serialClock), .ampGainTrim(ampGainTrim),
  .lowPowerTrim(lowPowerTrim), .analogBusPinConnect(analogBusPinConnect), .p1Cfg(p1Cfg),
  .serialClockP10(serialClockP10), .serialClockP13(serialClockP13), .gpioReq(gpioReq)
);

// ===== verif/iocfg_bank_tb.sv
`timescale 1ns/100ps
`define CHK(a, e) begin nChecks++; if ((a) !== (e)) begin fails++; \
  $display("Error t=%0t got %h exp %h", $time, (a), (e)); end end
module iocfg_bank_tb import iocfg_pkg::*;;
  // ******
  // Stimulus and observed signals
  // ******
  logic sys_clk = 0;
  logic rst = 1;
  logic cyc = 0, stb = 0, we = 0, sclk = 0;
  logic [9:0] adr = '0;
  logic [3:0] sel = '0;
  logic [31:0] dat = '0;
  logic [31:0] datO;
  logic ack, p10, p13, gpioReq, irq;
  logic [4:0][7:0] pins = '1;
  logic [4:0][7:0] conn;
  logic [4:0][7:0] connExp = '0;
  logic [2:0] gain;
  logic [1:0] lp;
  iocfg_p1cfg_s p1;
  logic [7:0] expQ[$];
  logic [7:0] e;
  logic [7:0] muxIdx [5] = '{IDX_MUX0, IDX_MUX1, IDX_MUX2, IDX_MUX3, IDX_MUX4};
  int fails = 0;
  int nChecks = 0;

  iocfg_bank uut (.sys_clk(sys_clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(datO), .wb_ack_o(ack),
    .pinLevel(pins), .serialClock(sclk), .ampGainTrim(gain), .lowPowerTrim(lp),
    .analogBusPinConnect(conn), .p1Cfg(p1), .serialClockP10(p10), .serialClockP13(p13),
    .gpioReq(gpioReq), .irq(irq));

  // 250 MHz system clock
  initial begin
    forever #2 sys_clk = ~sys_clk;
  end

  task automatic print_verdict();
    if (fails == 0 && nChecks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // One classic cycle; entered just after a rising edge, leaves one idle cycle
  task automatic wbAcc(input logic w, input logic [7:0] idx, input logic [7:0] d,
                       input logic [3:0] s = 4'h1);
    int k;
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= {idx, 2'b00};
    dat <= {24'h0, d};
    sel <= s;
    k = 0;
    do begin
      @(posedge sys_clk);
      k++;
    end while (ack !== 1'b1 && k < 50);
    cyc <= 0;
    stb <= 0;
    we <= 0;
    if (ack !== 1'b1) begin
      fails++;
      print_verdict();
    end else begin
      @(posedge sys_clk);
    end
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    wbAcc(1'b1, idx, d);
  endtask

  // The expectation is queued before the read goes out
  task automatic rd(input logic [7:0] idx, input logic [7:0] x);
    expQ.push_back(x);
    wbAcc(1'b0, idx, 8'h00);
  endtask

  // Read monitor: the oldest note is matched at each read acknowledge
  always @(posedge sys_clk) begin
    if (ack === 1'b1 && we === 1'b0) begin
      if (expQ.size() == 0) begin
        `CHK(datO, 32'hx)
      end else begin
        e = expQ.pop_front();
        `CHK(datO, {24'h0, e})
      end
    end
  end

  // Hang guard, counted as a mismatch
  initial begin
    repeat (20000) @(posedge sys_clk);
    fails++;
    print_verdict();
  end

  // ******
  // Main sequence
  // ******
  initial begin
    logic [7:0] v;
    int p;
    void'($urandom(28));
    repeat (12) @(posedge sys_clk);
    rst <= 0;
    @(posedge sys_clk);
    `CHK({gain, lp}, 5'h14)
    `CHK(p1, 7'h00)
    `CHK(conn, connExp)
    rd(IDX_TRIM, 8'h14);
    rd(IDX_P1CFG, 8'h00);
    // Random switch patterns, each landing on its own port only
    for (p = 0; p < 5; p++) begin
      rd(muxIdx[p], 8'h00);
      v = 8'($urandom());
      wr(muxIdx[p], v);
      connExp[p] = (p == 4) ? (v & PORT4_PIN_MASK) : v;
      `CHK(conn, connExp)
      rd(muxIdx[p], connExp[p]);
    end
    // Unmapped place reads zero; a write without byte lane 0 is dropped
    rd(8'h10, 8'h00);
    wbAcc(1'b1, IDX_MUX2, ~connExp[2], 4'he);
    `CHK(conn, connExp)
    // Every high level code, reserved bit 6 kept zero by software
    for (p = 0; p < 4; p++) begin
      v = 8'($urandom());
      v[6] = 1'b0;
      v[5:4] = 2'(p);
      wr(IDX_P1CFG, v);
      `CHK(p1, {v[7], v[5:0]})
      sclk <= 1;
      @(negedge sys_clk);
      `CHK({p10, p13}, {v[2], !v[2]})
      @(posedge sys_clk);
      sclk <= 0;
      rd(IDX_P1CFG, v);
    end
    // Trim write event: raise, mask, unmask, clear
    wr(IDX_IMASK, 8'h02);
    wr(IDX_TRIM, 8'h08);
    `CHK({gain, lp}, 5'h08)
    `CHK(irq, 1'b1)
    wr(IDX_TRIM, 8'h14);
    wr(IDX_IMASK, 8'h00);
    `CHK(irq, 1'b0)
    wr(IDX_IMASK, 8'h02);
    `CHK(irq, 1'b1)
    wr(IDX_STAT, 8'h02);
    `CHK(irq, 1'b0)
    // Low-level style: needs pin enable and global mask
    wr(IDX_P1CFG, 8'h00);
    wr(IDX_PIE0, 8'h01);
    pins[0][0] <= 1'b0;
    repeat (3) @(posedge sys_clk);
    `CHK(gpioReq, 1'b0)
    wr(IDX_GMASK, 8'h01);
    `CHK(gpioReq, 1'b1)
    pins[0][0] <= 1'b1;
    repeat (3) @(posedge sys_clk);
    `CHK(gpioReq, 1'b0)
    // Change style against the copy taken at each port read
    wr(IDX_P1CFG, 8'h01);
    rd(IDX_PDATA0, 8'hff);
    repeat (2) @(posedge sys_clk);
    `CHK(gpioReq, 1'b0)
    pins[0][0] <= 1'b0;
    repeat (3) @(posedge sys_clk);
    `CHK(gpioReq, 1'b1)
    rd(IDX_PDATA0, 8'hfe);
    pins[0][1] <= 1'b0;
    repeat (3) @(posedge sys_clk);
    `CHK(gpioReq, 1'b0)
    // Sticky GPIO status bit drives the level interrupt once unmasked
    rd(IDX_STAT, 8'h01);
    wr(IDX_IMASK, 8'h01);
    `CHK(irq, 1'b1)
    wr(IDX_STAT, 8'h01);
    `CHK(irq, 1'b0)
    // Enable and mask words read back; port 4 keeps only its four pins
    wr(IDX_PIE0 + 8'h04, 8'hff);
    rd(IDX_PIE0 + 8'h04, 8'h0f);
    rd(IDX_GMASK, 8'h01);
    rd(IDX_IMASK, 8'h01);
    // Reset again in mid-run: every register returns to its reset value
    rst <= 1;
    repeat (2) @(posedge sys_clk);
    rst <= 0;
    @(posedge sys_clk);
    `CHK({gain, lp}, 5'h14)
    `CHK({p1, conn}, 47'h0)
    `CHK(irq, 1'b0)
    rd(IDX_PIE0 + 8'h04, 8'h00);
    rd(IDX_GMASK, 8'h00);
    print_verdict();
  end
endmodule

// ===== verilog/iocfg_bank.sv
// Our own choice: the Wishbone slave port.
`timescale 1ns/100ps
// ****************************************
// I/O configuration register bank
// ****************************************
module iocfg_bank import iocfg_pkg::*; #(
  parameter int ADDR_W = 10,
  parameter int NPORTS = IOCFG_NPORTS,
  parameter int PINS = IOCFG_PINS
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,

  // Wishbone register bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,

  // Port pins
  input wire logic [NPORTS-1:0][PINS-1:0] pinLevel,
  input wire logic serialClock,

  // Crystal oscillator trim
  output logic [2:0] ampGainTrim,
  output logic [1:0] lowPowerTrim,

  // Analog mux bus switches
  output logic [NPORTS-1:0][PINS-1:0] analogBusPinConnect,

  // Port 1 configuration and serial clock routing
  output iocfg_p1cfg_s p1Cfg,
  output logic serialClockP10,
  output logic serialClockP13,

  // Interrupts
  output logic gpioReq,
  output logic irq
);

  // ****************************************
  // Declarations
  // ****************************************
  // Decoded access from the slave and the byte it reads back
  iocfg_req_s req;
  logic [7:0] rdData;
  logic [7:0] next_rdData;

  // GPIO interrupt configuration
  logic [NPORTS-1:0][PINS-1:0] perPinIrqEnable;
  logic gpioMaskBit;
  logic [NPORTS-1:0] portReadStb;

  // Interrupt status, mask and one-cycle event strobes
  logic [EV_NUM-1:0] irqStatus;
  logic [EV_NUM-1:0] irqMask;
  logic [EV_NUM-1:0] events;
  logic gpioReqLast;

  // ****************************************
  // Helpers
  // ****************************************

  // True when idx falls in a per-port block starting at base
  function automatic logic inPortBlock(input logic [7:0] idx, input logic [7:0] base);
    logic [7:0] off;
    off = idx - base;
    return (idx >= base) && (off < 8'(NPORTS));
  endfunction

  // Port number inside a per-port block
  function automatic int portOf(input logic [7:0] idx, input logic [7:0] base);
    logic [7:0] off;
    off = idx - base;
    return int'(off);
  endfunction

  // Index of the analog connect register of a port, or zero if none
  function automatic logic [7:0] muxIdxOf(input int port);
    logic [7:0] res;
    res = 8'h00;
    case (port)
      0: res = IDX_MUX0;
      1: res = IDX_MUX1;
      2: res = IDX_MUX2;
      3: res = IDX_MUX3;
      4: res = IDX_MUX4;
      default: res = 8'h00;
    endcase
    return res;
  endfunction

  // Pins that physically exist on a port; port 4 has only four
  function automatic logic [PINS-1:0] pinMaskOf(input int port);
    logic [PINS-1:0] res;
    res = '1;
    if (port == 4) begin
      res = PORT4_PIN_MASK[PINS-1:0];
    end
    return res;
  endfunction

  // ****************************************
  // Bus front end
  // ****************************************
  iocfg_wb_slave #(
    .ADDR_W(ADDR_W)
  ) u_slave (
    .sys_clk(sys_clk),
    .rst(rst),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o),
    .req(req),
    .rdData(rdData)
  );

  // ****************************************
  // Crystal oscillator trim
  // ****************************************

  // Both trim fields stay writable so firmware can restore the reset code;
  // any write is also flagged in the status register as a possible mistake
  // RL1 gain trim, reset 101
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ampGainTrim <= RST_GAIN;
    end else if (req.wr && req.idx == IDX_TRIM) begin
      ampGainTrim <= req.data[TRIM_GAIN_LSB +: 3];
    end
  end

  // RL2 low power trim, reset 00
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      lowPowerTrim <= RST_LP;
    end else if (req.wr && req.idx == IDX_TRIM) begin
      lowPowerTrim <= req.data[TRIM_LP_LSB +: 2];
    end
  end

  // ****************************************
  // Analog mux bus connections
  // ****************************************

  // Several pins may share the bus at once; nothing here keeps them exclusive
  // RL5 one bit per pin switch
  // RL6 register per port, bit per pin
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      for (int p = 0; p < NPORTS; p++) begin
        analogBusPinConnect[p] <= RST_CONN[PINS-1:0];
      end
    end else begin
      for (int p = 0; p < NPORTS; p++) begin
        if (req.wr && req.idx == muxIdxOf(p)) begin
          // RL7 missing pins stay zero
          analogBusPinConnect[p] <= req.data[PINS-1:0] & pinMaskOf(p);
        end
      end
    end
  end

  // ****************************************
  // Port 1 output configuration
  // ****************************************

  // RL8 strong drive, RL9 level, RL10 threshold, RL12 regulator
  // Reserved bit 6 is dropped, so a careless write cannot leave state there
  // Level codes 00 and 01 both mean 3.0 V; the code is kept as written
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      p1Cfg <= '0;
    end else if (req.wr && req.idx == IDX_P1CFG) begin
      p1Cfg.strongHighDrive <= req.data[P1_STRONG];
      p1Cfg.highLevel <= iocfg_range_e'(req.data[P1_RANGE_LSB +: 2]);
      p1Cfg.inputThresholdReduce <= req.data[P1_THR];
      p1Cfg.serialClockPinSelect <= req.data[P1_SPI];
      p1Cfg.regulatorEnable <= req.data[P1_REG];
      p1Cfg.irqOnChange <= req.data[P1_INT];
    end
  end

  // RL11 serial clock routing
  // Plain gating: the unselected pin rests low rather than toggling
  assign serialClockP10 = serialClock & p1Cfg.serialClockPinSelect;
  assign serialClockP13 = serialClock & ~p1Cfg.serialClockPinSelect;

  // ****************************************
  // GPIO interrupt controls
  // ****************************************

  // Per-pin interrupt enables, one register per port
  // Absent port 4 pins are masked so they can never raise a request
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      perPinIrqEnable <= '0;
    end else begin
      for (int p = 0; p < NPORTS; p++) begin
        if (req.wr && inPortBlock(req.idx, IDX_PIE0) && portOf(req.idx, IDX_PIE0) == p) begin
          perPinIrqEnable[p] <= req.data[PINS-1:0] & pinMaskOf(p);
        end
      end
    end
  end

  // Global GPIO mask bit
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      gpioMaskBit <= 1'b0;
    end else if (req.wr && req.idx == IDX_GMASK) begin
      gpioMaskBit <= req.data[0];
    end
  end

  // RL15 a read of a port data register is what arms change detection
  always_comb begin
    portReadStb = '0;
    for (int p = 0; p < NPORTS; p++) begin
      portReadStb[p] = req.rd && inPortBlock(req.idx, IDX_PDATA0)
        && portOf(req.idx, IDX_PDATA0) == p;
    end
  end

  // RL13 RL14 request from style, enables and mask
  iocfg_pin_irq #(
    .NPORTS(NPORTS),
    .PINS(PINS)
  ) u_pin_irq (
    .sys_clk(sys_clk),
    .rst(rst),
    .pinLevel(pinLevel),
    .perPinIrqEnable(perPinIrqEnable),
    .irqOnChange(p1Cfg.irqOnChange),
    .gpioMaskBit(gpioMaskBit),
    .portReadStb(portReadStb),
    .gpioReq(gpioReq)
  );

  // ****************************************
  // Interrupt status and mask
  // ****************************************

  // Edge of the GPIO request is one event
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      gpioReqLast <= 1'b0;
    end else begin
      gpioReqLast <= gpioReq;
    end
  end

  // Events: new GPIO request, and any write to the trim register
  // Only the rising edge counts, so a standing request does not refill status
  always_comb begin
    events = '0;
    events[EV_GPIO] = gpioReq & ~gpioReqLast;
    events[EV_TRIM] = req.wr && req.idx == IDX_TRIM;
  end

  // Sticky status, write one to clear; a new event wins over the clear
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      irqStatus <= '0;
    end else begin
      for (int e = 0; e < EV_NUM; e++) begin
        if (events[e]) begin
          irqStatus[e] <= 1'b1;
        end else if (req.wr && req.idx == IDX_STAT && req.data[e]) begin
          irqStatus[e] <= 1'b0;
        end
      end
    end
  end

  // Interrupt mask, same layout as status
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      irqMask <= '0;
    end else if (req.wr && req.idx == IDX_IMASK) begin
      irqMask <= req.data[EV_NUM-1:0];
    end
  end

  // Level interrupt while any unmasked status bit stands
  // Kept combinational from flops, so it drops in the cycle the clear lands
  assign irq = |(irqStatus & irqMask);

  // ****************************************
  // Read back
  // ****************************************

  // Read mux; holes read zero, reserved bits read zero
  // Reserved positions are never stored; port 4 connect and pin reads are also masked here
  always_comb begin
    next_rdData = 8'h00;
    if (req.idx == IDX_TRIM) begin
      next_rdData[TRIM_GAIN_LSB +: 3] = ampGainTrim;
      next_rdData[TRIM_LP_LSB +: 2] = lowPowerTrim;
    end else if (req.idx == IDX_P1CFG) begin
      next_rdData[P1_STRONG] = p1Cfg.strongHighDrive;
      next_rdData[P1_RANGE_LSB +: 2] = p1Cfg.highLevel;
      next_rdData[P1_THR] = p1Cfg.inputThresholdReduce;
      next_rdData[P1_SPI] = p1Cfg.serialClockPinSelect;
      next_rdData[P1_REG] = p1Cfg.regulatorEnable;
      next_rdData[P1_INT] = p1Cfg.irqOnChange;
    end else if (req.idx == IDX_GMASK) begin
      next_rdData[0] = gpioMaskBit;
    end else if (req.idx == IDX_STAT) begin
      next_rdData[EV_NUM-1:0] = irqStatus;
    end else if (req.idx == IDX_IMASK) begin
      next_rdData[EV_NUM-1:0] = irqMask;
    end else begin
      for (int p = 0; p < NPORTS; p++) begin
        if (req.idx == muxIdxOf(p)) begin
          // RL7 upper port 4 bits read zero
          next_rdData[PINS-1:0] = analogBusPinConnect[p] & pinMaskOf(p);
        end
        if (inPortBlock(req.idx, IDX_PIE0) && portOf(req.idx, IDX_PIE0) == p) begin
          next_rdData[PINS-1:0] = perPinIrqEnable[p];
        end
        if (inPortBlock(req.idx, IDX_PDATA0) && portOf(req.idx, IDX_PDATA0) == p) begin
          next_rdData[PINS-1:0] = pinLevel[p] & pinMaskOf(p);
        end
      end
    end
  end

  // The slave registers this into wb_dat_o at the take edge
  assign rdData = next_rdData;

endmodule

// ===== verilog/iocfg_pin_irq.sv
`timescale 1ns/100ps
// ****************************************
// GPIO interrupt request generator
// ****************************************
module iocfg_pin_irq import iocfg_pkg::*; #(
  parameter int NPORTS = IOCFG_NPORTS,
  parameter int PINS = IOCFG_PINS
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Pins and configuration
  input wire logic [NPORTS-1:0][PINS-1:0] pinLevel,
  input wire logic [NPORTS-1:0][PINS-1:0] perPinIrqEnable,
  input wire logic irqOnChange,
  input wire logic gpioMaskBit,
  input wire logic [NPORTS-1:0] portReadStb,
  // Request
  output logic gpioReq
);

  logic [NPORTS-1:0][PINS-1:0] captured;
  logic [NPORTS-1:0][PINS-1:0] hit;

  // RL15 capture on read
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      captured <= '0;
    end else begin
      for (int p = 0; p < NPORTS; p++) begin
        if (portReadStb[p]) begin
          captured[p] <= pinLevel[p];
        end
      end
    end
  end

  // RL13 style select
  assign hit = irqOnChange ? (pinLevel ^ captured) : ~pinLevel;

  // RL14 enables gate request; registered to keep pin glitches off the core
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      gpioReq <= 1'b0;
    end else begin
      gpioReq <= gpioMaskBit & (|(hit & perPinIrqEnable));
    end
  end

endmodule

// ===== verilog/iocfg_wb_slave.sv
`timescale 1ns/100ps
// ****************************************
// Classic Wishbone slave front end
// ****************************************
module iocfg_wb_slave import iocfg_pkg::*; #(
  parameter int ADDR_W = 10
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Wishbone
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Register side
  output iocfg_req_s req,
  input wire logic [7:0] rdData
);

  logic take;

  // One access per request; ack high blocks a second take
  assign take = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  // Only lane 0 carries register data, upper lanes are ignored
  assign req.wr = take & wb_we_i & wb_sel_i[0];
  assign req.rd = take & ~wb_we_i;
  assign req.idx = wb_adr_i[9:2];
  assign req.data = wb_dat_i[7:0];

  // Ack one cycle after the take, dropped the cycle after
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= take;
    end
  end

  // Read data captured with the ack; zero for writes and holes
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wb_dat_o <= 32'h00000000;
    end else if (take) begin
      wb_dat_o <= wb_we_i ? 32'h00000000 : {24'h000000, rdData};
    end
  end

endmodule
